// *** common/dac_pair_map.vh ***
// Purpose: Constants for the dual converter update and format control block
// Assumes: Registers sit on a paged byte-wide special-function bus
// Notes:   Offsets are bus addresses; page selects which channel a name reaches
// Function
// - Enable bit 7 at 0 disables output pin and shuts converter down.
// - Enable bit 7 at 1 drives output pin and runs converter.
// - Control bits 6 and 5 read zero; writes to them ignored.
// - Trigger 00 latches staged word on a high byte write.
// - Trigger 01 timer 3, 10 timer 4, 11 timer 2 overflow.
// - Format 000: word is high[3:0] and low[7:0].
// - Format 001: word is high[4:0] and low[7:1].
// - Format 010: word is high[5:0] and low[7:2].
// - Format 011: word is high[6:0] and low[7:3].
// - Format 1xx: word is high[7:0] and low[7:4].
// - Channel 0 low data register is eight-bit read/write.
// - Channel 1 high data register is eight-bit read/write.
// - Channel 1 high data decoded at 0xD3 on page 1.
// - Channel 1 low data decoded at 0xD2 on page 1.
// - Channel 0 control decoded at 0xD4 on page 0.
// - On demand, low byte write only staged until high byte write.
// - Timer modes hold both bytes, copy on selected overflow.
// - Channel 1 behaves like channel 0 with page 1 registers.
// - Assembled word is twelve-bit unsigned, 0x000 to 0xFFF.
`ifndef DAC_PAIR_MAP_VH
`define DAC_PAIR_MAP_VH
`define ADDR_DATA_LOW   8'hD2
`define ADDR_DATA_HIGH  8'hD3
`define ADDR_CONTROL    8'hD4
`define PAGE_CH0        8'h00
`define PAGE_CH1        8'h01
`define CTRL_RESET      8'h00
`define DATA_RESET      8'h00
`define WORD_RESET      12'h000
`define CTRL_WMASK      8'h9F
`define BIT_ENABLE      7
`define TRIG_HI         4
`define TRIG_LO         3
`define FMT_HI          2
`define FMT_LO          0
`define TRIG_ON_WRITE   2'h0
`define TRIG_TIMER3     2'h1
`define TRIG_TIMER4     2'h2
`define TRIG_TIMER2     2'h3
`define FMT_4_8         3'h0
`define FMT_5_7         3'h1
`define FMT_6_6         3'h2
`define FMT_7_5         3'h3
`endif

// *** core/dac_channel.v ***
// Purpose: One converter channel: data bytes, control, format and update latch
// Assumes: Write strobes are one cycle and already decoded for this channel
// Notes:   Timer strobes are same-clock one-cycle overflow pulses
`timescale 1ns/1ns
`default_nettype none
`include "dac_pair_map.vh"
module dac_channel (
   input  wire        clk,
   input  wire        reset,
   input  wire [7:0]  wdata,
   input  wire        wr_low,
   input  wire        wr_high,
   input  wire        wr_ctrl,
   input  wire        tmr2_ovf,
   input  wire        tmr3_ovf,
   input  wire        tmr4_ovf,
   output reg  [7:0]  data_low_q,
   output reg  [7:0]  data_high_q,
   output wire [7:0]  control,
   output reg  [11:0] latch_q,
   output reg         enable_q
);
   reg  [1:0]  trig_q;
   reg  [2:0]  fmt_q;
   reg  [11:0] word_d;
   reg         update;
   localparam [7:0] CTRL_INIT = `CTRL_RESET;
   // Unused bits are simply not stored, so they read zero
   assign control = {enable_q, 2'b00, trig_q, fmt_q};

   // Register storage; every bit of the data bytes is kept
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         data_low_q  <= `DATA_RESET;
         data_high_q <= `DATA_RESET;
         enable_q    <= CTRL_INIT[`BIT_ENABLE];
         trig_q      <= CTRL_INIT[`TRIG_HI:`TRIG_LO];
         fmt_q       <= CTRL_INIT[`FMT_HI:`FMT_LO];
      end else begin
         if (wr_low)
            data_low_q <= wdata;
         if (wr_high)
            data_high_q <= wdata;
         if (wr_ctrl) begin
            enable_q <= wdata[`BIT_ENABLE];
            trig_q   <= wdata[`TRIG_HI:`TRIG_LO];
            fmt_q    <= wdata[`FMT_HI:`FMT_LO];
         end
      end
   end

   // Word assembly from the stored bytes; format is taken at latch time
   always @* begin
      case (fmt_q)
         `FMT_4_8: word_d = {data_high_q[3:0], data_low_q};
         `FMT_5_7: word_d = {data_high_q[4:0], data_low_q[7:1]};
         `FMT_6_6: word_d = {data_high_q[5:0], data_low_q[7:2]};
         `FMT_7_5: word_d = {data_high_q[6:0], data_low_q[7:3]};
         default:  word_d = {data_high_q, data_low_q[7:4]};
      endcase
   end

   // Update event; high byte write commits one cycle after its strobe
   always @* begin
      case (trig_q)
         `TRIG_ON_WRITE: update = 1'b0;
         `TRIG_TIMER3:   update = tmr3_ovf;
         `TRIG_TIMER4:   update = tmr4_ovf;
         default:        update = tmr2_ovf;
      endcase
   end

   // Delayed write flag lets the latch see the freshly stored high byte
   reg wr_high_q;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_high_q <= 1'b0;
         latch_q   <= `WORD_RESET;
      end else begin
         wr_high_q <= wr_high && (trig_q == `TRIG_ON_WRITE);
         if (wr_high_q || update)
            latch_q <= word_d;
      end
   end
endmodule // dac_channel
`default_nettype wire

// *** core/dac_pair_ctrl.v ***
// Purpose: Two-channel converter front end on a paged register port
// Assumes: Bus master on clk; page selector held stable across an access
// Notes:   Analog stage gets latched words, enables and shutdown levels
//          Read data stand one cycle after the read strobe, zero otherwise
//          Pages other than 0 and 1 are holes: writes vanish, reads give zero
//          A high byte write in on-demand mode reaches the word two edges later
//          In timer modes the word changes at the edge that takes the overflow
`timescale 1ns/1ns
`default_nettype none
`include "dac_pair_map.vh"
module dac_pair_ctrl (
   input  wire        clk,
   input  wire        reset,
   input  wire [7:0]  addr,
   input  wire [7:0]  page,
   input  wire [7:0]  wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [7:0]  rdata,
   input  wire        tmr2_ovf,
   input  wire        tmr3_ovf,
   input  wire        tmr4_ovf,
   output wire [11:0] ch0_word,
   output wire [11:0] ch1_word,
   output wire        ch0_out_oe_n,
   output wire        ch1_out_oe_n,
   output wire        ch0_shutdown,
   output wire        ch1_shutdown
);
   // Register map seen from the bus:
   //   page 0: low byte, high byte and control of channel 0
   //   page 1: low byte, high byte and control of channel 1
   //   any other page, or any other address, is a hole
   // The channels keep all storage; this level only decodes and reads back.
   // Both channels share the three timer overflow strobes; each picks its own.

   // Read source codes; the idle code reads as zero
   localparam [2:0] SRC_NONE = 3'b000;
   localparam [2:0] SRC_LO0  = 3'b001;
   localparam [2:0] SRC_HI0  = 3'b010;
   localparam [2:0] SRC_CN0  = 3'b011;
   localparam [2:0] SRC_LO1  = 3'b100;
   localparam [2:0] SRC_HI1  = 3'b101;
   localparam [2:0] SRC_CN1  = 3'b110;

   // Page hits
   wire        sel0;
   wire        sel1;

   // Decoded write strobes, one per register
   reg         wr_low0;
   reg         wr_high0;
   reg         wr_ctrl0;
   reg         wr_low1;
   reg         wr_high1;
   reg         wr_ctrl1;

   // Read source for the coming cycle and the byte it picks
   reg  [2:0]  src_d;
   reg  [7:0]  rdata_d;

   // Register contents as the channels hold them
   wire [7:0]  lo0;
   wire [7:0]  hi0;
   wire [7:0]  cn0;
   wire [7:0]  lo1;
   wire [7:0]  hi1;
   wire [7:0]  cn1;
   wire        en0;
   wire        en1;

   // Only pages 0 and 1 carry registers; any other page is a hole
   assign sel0 = (page == `PAGE_CH0);
   assign sel1 = (page == `PAGE_CH1);

   // Page 0 write decode; one strobe in, at most one strobe out
   always @* begin
      wr_low0  = 1'b0;
      wr_high0 = 1'b0;
      wr_ctrl0 = 1'b0;
      if (wr && sel0) begin
         case (addr)
            `ADDR_DATA_LOW: begin
               wr_low0 = 1'b1;
            end
            `ADDR_DATA_HIGH: begin
               wr_high0 = 1'b1;
            end
            `ADDR_CONTROL: begin
               wr_ctrl0 = 1'b1;
            end
            default: begin
               wr_low0 = 1'b0;
            end
         endcase
      end
   end

   // Page 1 write decode; same addresses, other channel
   always @* begin
      wr_low1  = 1'b0;
      wr_high1 = 1'b0;
      wr_ctrl1 = 1'b0;
      if (wr && sel1) begin
         case (addr)
            `ADDR_DATA_LOW: begin
               wr_low1 = 1'b1;
            end
            `ADDR_DATA_HIGH: begin
               wr_high1 = 1'b1;
            end
            `ADDR_CONTROL: begin
               wr_ctrl1 = 1'b1;
            end
            default: begin
               wr_low1 = 1'b0;
            end
         endcase
      end
   end

   // Read source; registered below so the data stand one cycle later
   always @* begin
      src_d = SRC_NONE;
      if (rd && sel0) begin
         case (addr)
            `ADDR_DATA_LOW: begin
               src_d = SRC_LO0;
            end
            `ADDR_DATA_HIGH: begin
               src_d = SRC_HI0;
            end
            `ADDR_CONTROL: begin
               src_d = SRC_CN0;
            end
            default: begin
               src_d = SRC_NONE;
            end
         endcase
      end else if (rd && sel1) begin
         case (addr)
            `ADDR_DATA_LOW: begin
               src_d = SRC_LO1;
            end
            `ADDR_DATA_HIGH: begin
               src_d = SRC_HI1;
            end
            `ADDR_CONTROL: begin
               src_d = SRC_CN1;
            end
            default: begin
               src_d = SRC_NONE;
            end
         endcase
      end
   end

   // Read multiplexer; holes and idle cycles give zero so nothing stale leaks
   always @* begin
      rdata_d = `DATA_RESET;
      case (src_d)
         SRC_LO0: rdata_d = lo0;
         SRC_HI0: rdata_d = hi0;
         SRC_CN0: rdata_d = cn0;
         SRC_LO1: rdata_d = lo1;
         SRC_HI1: rdata_d = hi1;
         SRC_CN1: rdata_d = cn1;
         default: rdata_d = `DATA_RESET;
      endcase
   end

   // Read data register; back to zero in every cycle without a read
   always @(posedge clk or posedge reset) begin
      if (reset)
         rdata <= `DATA_RESET;
      else
         rdata <= rdata_d;
   end

   // Channel 0 on page 0
   dac_channel u_ch0 (
      .clk        (clk),
      .reset      (reset),
      .wdata      (wdata),
      .wr_low     (wr_low0),
      .wr_high    (wr_high0),
      .wr_ctrl    (wr_ctrl0),
      .tmr2_ovf   (tmr2_ovf),
      .tmr3_ovf   (tmr3_ovf),
      .tmr4_ovf   (tmr4_ovf),
      .data_low_q (lo0),
      .data_high_q(hi0),
      .control    (cn0),
      .latch_q    (ch0_word),
      .enable_q   (en0)
   );

   // Channel 1 on page 1, same behaviour
   dac_channel u_ch1 (
      .clk        (clk),
      .reset      (reset),
      .wdata      (wdata),
      .wr_low     (wr_low1),
      .wr_high    (wr_high1),
      .wr_ctrl    (wr_ctrl1),
      .tmr2_ovf   (tmr2_ovf),
      .tmr3_ovf   (tmr3_ovf),
      .tmr4_ovf   (tmr4_ovf),
      .data_low_q (lo1),
      .data_high_q(hi1),
      .control    (cn1),
      .latch_q    (ch1_word),
      .enable_q   (en1)
   );

   // Output pin drive and shutdown follow the enable bits
   assign ch0_out_oe_n = ~en0;
   assign ch1_out_oe_n = ~en1;
   assign ch0_shutdown = ~en0;
   assign ch1_shutdown = ~en1;
endmodule // dac_pair_ctrl
`default_nettype wire

// *** tb/dac_pair_ctrl_tb.sv ***
// Purpose: Self-checking bench for dac_pair_ctrl
// Assumes: Strobes change right after rising edges
// Notes:   Integer model of bytes, controls and words
`timescale 1ns/1ns
`default_nettype none
module dac_pair_ctrl_tb;
   logic        clk, reset, wr, rd, tmr2_ovf, tmr3_ovf, tmr4_ovf;
   logic        ch0_out_oe_n, ch1_out_oe_n, ch0_shutdown, ch1_shutdown;
   logic [7:0]  addr, page, wdata, rdata;
   logic [11:0] ch0_word, ch1_word;
   int          fails, n_compared, seed = 6, lo[2], hi[2], ct[2], wd[2];
   dac_pair_ctrl uut (.*);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic ck(string n, logic [11:0] s, logic [11:0] e);
      n_compared++;
      if (s !== e) fails++;
      if (s !== e) $display("[ERR] %s exp %h seen %h", n, e, s);
   endtask
   // One bus cycle; the model follows once the edge has taken it
   task automatic bus(bit w, bit r, int p, int a, int d, bit [2:0] t);
      {wr, rd, tmr4_ovf, tmr3_ovf, tmr2_ovf} <= {w, r, t};
      {page, addr, wdata} <= {p[7:0], a[7:0], d[7:0]};
      @(posedge clk);
      if (w && p < 2 && a == 8'hD2) lo[p] = d & 8'hFF;
      if (w && p < 2 && a == 8'hD3) hi[p] = d & 8'hFF;
      if (w && p < 2 && a == 8'hD4) ct[p] = d & 8'h9F;
      for (int c = 0; c < 2; c++)
         if (ct[c][4:3] == 0 ? w && p == c && a == 8'hD3 : t[ct[c][4:3] % 3])
            wd[c] = (hi[c] << 8 | lo[c]) >> (ct[c][2] ? 4 : ct[c][1:0]) & 12'hFFF;
   endtask
   task automatic rdc(int p, int a, int e);
      bus(0, 1, p, a, 0, 0);
      #1 ck("rdata", rdata, e[7:0]);
   endtask
   // Two idle edges let an on-demand update land
   task automatic outs();
      repeat (2) bus(0, 0, 0, 0, 0, 0);
      #1 ck("word0", ch0_word, wd[0]);
      ck("word1", ch1_word, wd[1]);
      ck("enable", {ch0_out_oe_n, ch0_shutdown, ch1_out_oe_n, ch1_shutdown},
         {{2{!ct[0][7]}}, {2{!ct[1][7]}}});
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      report_and_stop();
   end
   initial begin
      {wr, rd, tmr2_ovf, tmr3_ovf, tmr4_ovf, page, addr, wdata} = 29'h0;
      reset = 1'b1;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      for (int a = 8'hD2; a < 8'hD5; a++) rdc(a & 1, a, 0);
      outs();
      $display("reset test done");
      // Every format and trigger per channel, junk in the unused control bits
      for (int i = 0; i < 16; i++) begin
         bus(1, 0, i % 2, 8'hD4, 8'h60 & $random(seed) | 8'h80 | i / 2 % 4 << 3 | i / 2, 0);
         bus(1, 0, i % 2, 8'hD2, $random(seed), 0);
         rdc(i % 2, 8'hD2, lo[i % 2]);
         outs();
         bus(1, 0, i % 2, 8'hD3, $random(seed), 0);
         rdc(i % 2, 8'hD3, hi[i % 2]);
         for (int t = 0; t < 4; t++) begin
            outs();
            bus(0, 0, 0, 0, 0, 3'h1 << t);
         end
         rdc(i % 2, 8'hD4, ct[i % 2]);
      end
      $display("format and trigger test done");
      bus(1, 0, 0, 8'hD4, 8'h00, 0);
      bus(1, 0, 2, 8'hD2, 8'hFF, 0);
      rdc(2, 8'hD2, 0);
      rdc(0, 8'hD2, lo[0]);
      outs();
      $display("shutdown and unmapped test done");
      report_and_stop();
   end
endmodule // dac_pair_ctrl_tb
`default_nettype wire

// *** tb/dac_pair_monitor.sv ***
// Purpose: Port assertions for dac_pair_ctrl
// Assumes: One clock, reset async high
// Notes:   Sees only the ports of dac_pair_ctrl
`timescale 1ns/1ns
`default_nettype none
module dac_pair_monitor (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic        tmr2_ovf,
   input wire logic        tmr3_ovf,
   input wire logic        tmr4_ovf,
   input wire logic        ch0_out_oe_n,
   input wire logic        ch1_out_oe_n,
   input wire logic        ch0_shutdown,
   input wire logic        ch1_shutdown,
   input wire logic [7:0]  addr,
   input wire logic [7:0]  page,
   input wire logic [7:0]  wdata,
   input wire logic [7:0]  rdata,
   input wire logic [11:0] ch0_word
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // One strobe aimed at one page and address
   sequence acc(s, p, a); s && page == p && addr == a; endsequence
   AST_EN0: assert property (acc(wr, 0, 8'hD4) |=> ch0_shutdown == !$past(wdata[7])
      && ch0_out_oe_n == ch0_shutdown) else $error("en0");
   AST_EN1: assert property (acc(wr, 1, 8'hD4) |=> ch1_shutdown == !$past(wdata[7])
      && ch1_out_oe_n == ch1_shutdown) else $error("en1");
   AST_LO0: assert property (acc(wr, 0, 8'hD2) ##1 acc(rd, 0, 8'hD2) |=>
      rdata == $past(wdata, 2)) else $error("lo0");
   AST_HI1: assert property (acc(wr, 1, 8'hD3) ##1 acc(rd, 1, 8'hD3) |=>
      rdata == $past(wdata, 2)) else $error("hi1");
   AST_CT3: assert property (rd && addr == 8'hD4 |=> rdata[6:5] == 2'h0) else $error("ct");
   AST_UNM: assert property (rd && page > 8'h01 |=> rdata == 8'h00) else $error("unm");
   // A word change needs its cause: a pulse just before or a write two cycles back
   AST_ODM: assert property ($changed(ch0_word) && !$past(tmr2_ovf | tmr3_ovf | tmr4_ovf)
      |-> $past(wr, 2) && $past(addr, 2) == 8'hD3 && $past(page, 2) == 8'h00)
      else $error("odm");
   AST_TMR: assert property ($changed(ch0_word) && !$past(wr, 2)
      |-> $past(tmr2_ovf | tmr3_ovf | tmr4_ovf)) else $error("tmr");
endmodule // dac_pair_monitor
bind dac_pair_ctrl dac_pair_monitor mon (.*);
`default_nettype wire
